// ===== sim/acp_card_model.sv
// acp_card_model: behavioural card in register-addressed mode
// assumes the host port strobes; released data lines fall to their pull-downs
module acp_card_model
(
   input wire logic core_clk,
   input wire logic slow,
   input wire logic task_n,
   input wire logic [2:0] addr,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [15:0] dout,
   input wire logic lo_oe,
   input wire logic hi_oe,
   output logic [15:0] din,
   output logic io_ready
);
   logic [15:0] mem [16];
   logic [5:0] cnt;
   always_comb
   begin
      din = {hi_oe ? dout[15:8] : 8'h00, lo_oe ? dout[7:0] : 8'h00};
      if (!rd_n && !lo_oe)
         din = mem[{task_n, addr}];
   end
   // a register write leaves the high lines to the card, which keeps junk there
   always @(posedge core_clk)
   begin
      if (!wr_n)
         mem[{task_n, addr}] <= {hi_oe ? din[15:8] : ~din[7:0], din[7:0]};
      cnt <= (rd_n & wr_n) ? 6'h00 : cnt + 6'h01;
   end
   assign io_ready = !(slow && !(rd_n & wr_n) && cnt < 6'h1e);
endmodule : acp_card_model

// ===== sim/acp_host_port_chk.sv
// acp_host_port_chk: pin-level checks of the card host port
// assumes one core_clk domain and rst active high
module acp_host_port_chk
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic card_irq,
   input wire logic card_irq_pending,
   input wire logic card_detect_a_n,
   input wire logic card_detect_b_n,
   input wire logic card_present,
   input wire logic card_task_select_n,
   input wire logic card_aux_select_n,
   input wire logic card_reg_addr_2,
   input wire logic card_reg_addr_1,
   input wire logic card_reg_addr_0,
   input wire logic card_read_strobe_n,
   input wire logic card_write_strobe_n,
   input wire logic card_hw_reset_n,
   input wire logic card_data_lo_oe,
   input wire logic card_data_hi_oe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic strobe_n;
   logic sel_n;
   logic [4:0] sel_addr;
   assign strobe_n = card_read_strobe_n & card_write_strobe_n;
   assign sel_n = card_task_select_n & card_aux_select_n;
   assign sel_addr = {card_task_select_n, card_aux_select_n, card_reg_addr_2, card_reg_addr_1, card_reg_addr_0};
   a_sel_one: assert property (card_task_select_n | card_aux_select_n)
      else $error("both selects low");
   a_strobe_sel: assert property ($fell(strobe_n) |-> !$past(sel_n))
      else $error("strobe without prior select");
   a_addr_held: assert property (!strobe_n && !$past(strobe_n) |-> $stable(sel_addr))
      else $error("select or address moved under strobe");
   a_strobe_excl: assert property (card_read_strobe_n | card_write_strobe_n)
      else $error("read and write strobes together");
   a_rd_width: assert property ($fell(card_read_strobe_n) |-> !card_read_strobe_n [*8])
      else $error("read strobe too short");
   a_wr_drive: assert property (!card_write_strobe_n |-> card_data_lo_oe)
      else $error("write strobe with bus released");
   a_rd_release: assert property (card_data_lo_oe |-> card_read_strobe_n && card_hw_reset_n)
      else $error("bus driven outside a write");
   a_hi_bulk: assert property (card_data_hi_oe |-> card_data_lo_oe)
      else $error("high byte driven alone");
   a_hw_reset: assert property ($fell(card_hw_reset_n) |-> (!card_hw_reset_n && strobe_n) [*8])
      else $error("card reset pulse broken");
   a_irq_seen: assert property (card_irq [*8] |-> card_irq_pending)
      else $error("card interrupt not reported");
   a_present: assert property ((!card_detect_a_n && !card_detect_b_n) [*8] |-> card_present)
      else $error("inserted card not reported");
   c_read: cover property ($fell(card_read_strobe_n));
   c_write: cover property ($fell(card_write_strobe_n));
   c_reset: cover property ($fell(card_hw_reset_n));
endmodule : acp_host_port_chk

bind acp_host_port acp_host_port_chk chk_u (.core_clk(core_clk), .rst(rst), .card_irq(card_irq),
   .card_irq_pending(card_irq_pending), .card_detect_a_n(card_detect_a_n), .card_detect_b_n(card_detect_b_n),
   .card_present(card_present), .card_task_select_n(card_task_select_n),
   .card_aux_select_n(card_aux_select_n), .card_reg_addr_2(card_reg_addr_2), .card_reg_addr_1(card_reg_addr_1),
   .card_reg_addr_0(card_reg_addr_0), .card_read_strobe_n(card_read_strobe_n),
   .card_write_strobe_n(card_write_strobe_n), .card_hw_reset_n(card_hw_reset_n),
   .card_data_lo_oe(card_data_lo_oe), .card_data_hi_oe(card_data_hi_oe));

// ===== sim/ata_card_host_port_test.sv
// ata_card_host_port_test: table of accesses, then stall, reset and status cases
// assumes acp_card_model as the card and the checker bound in
module ata_card_host_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import acp_pkg::*;
   typedef struct {logic w, aux, bulk; logic [2:0] a; logic [15:0] d, exp;} acp_row_t;
   acp_row_t rows [8] = '{'{1, 0, 1, 3'h0, 16'h1234, 0}, '{0, 0, 1, 3'h0, 0, 16'h1234},
      '{1, 0, 0, 3'h7, 16'hab5a, 0}, '{0, 0, 0, 3'h7, 0, 16'h005a}, '{1, 1, 0, 3'h6, 16'h77c3, 0},
      '{0, 1, 0, 3'h6, 0, 16'h00c3}, '{0, 0, 0, 3'h0, 0, 16'h0034}, '{0, 0, 1, 3'h7, 0, 16'ha55a}};
   logic core_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_aux = 0, req_bulk = 0, reset_req = 0;
   logic slow = 0, card_irq = 0, det_a_n = 1, det_b_n = 1;
   logic [2:0] req_addr = 0;
   logic [15:0] req_wdata = 0, rsp_rdata, din, dout;
   logic req_ready, rsp_valid, irq_p, present, ts_n, as_n, a2, a1, a0, rd_n, wr_n, hr_n, lo_oe, hi_oe, rdy;
   int errors = 0, checks_done = 0, cyc = 0, n;
   always #10 core_clk = ~core_clk;
   acp_host_port dut_u (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
      .req_aux(req_aux), .req_bulk(req_bulk), .req_addr(req_addr), .req_wdata(req_wdata),
      .reset_req(reset_req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .card_irq_pending(irq_p), .card_present(present), .card_task_select_n(ts_n), .card_aux_select_n(as_n),
      .card_reg_addr_2(a2), .card_reg_addr_1(a1), .card_reg_addr_0(a0), .card_read_strobe_n(rd_n),
      .card_write_strobe_n(wr_n), .card_hw_reset_n(hr_n), .card_data_lo_in(din[7:0]),
      .card_data_hi_in(din[15:8]), .card_data_lo_out(dout[7:0]), .card_data_hi_out(dout[15:8]),
      .card_data_lo_oe(lo_oe), .card_data_hi_oe(hi_oe), .card_irq(card_irq), .card_io_ready(rdy),
      .card_detect_a_n(det_a_n), .card_detect_b_n(det_b_n));
   acp_card_model card_u (.core_clk(core_clk), .slow(slow), .task_n(ts_n), .addr({a2, a1, a0}), .rd_n(rd_n),
      .wr_n(wr_n), .dout(dout), .lo_oe(lo_oe), .hi_oe(hi_oe), .din(din), .io_ready(rdy));
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task test_done;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task wait_for(input logic level, input int lim);
      n = 0;
      while (hr_n !== level && n < lim)
      begin
         @(negedge core_clk);
         n++;
      end
   endtask : wait_for
   task acc(input acp_row_t r);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 2000)
      begin
         @(negedge core_clk);
         k++;
      end
      {req_write, req_aux, req_bulk, req_addr, req_wdata, req_valid} = {r.w, r.aux, r.bulk, r.a, r.d, 1'b1};
      @(negedge core_clk);
      req_valid = 0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 300)
      begin
         @(negedge core_clk);
         n++;
         if (k >= 0 && (rd_n & wr_n) === 1'b0)
         begin
            chk("addr", 16'({a2, a1, a0}), 16'(r.a));
            chk("select", 16'({ts_n, as_n}), r.aux ? 16'h0002 : 16'h0001);
            chk("strobe", 16'({rd_n, wr_n}), r.w ? 16'h0002 : 16'h0001);
            k = -1;
         end
      end
      chk("done", 16'(rsp_valid), 16'h0001);
      if (!r.w)
         chk("rdata", rsp_rdata, r.exp);
   endtask : acc
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         errors++;
         test_done();
      end
   end
   initial
   begin
      repeat (10) @(negedge core_clk);
      chk("rst_pins", 16'({hr_n, ts_n, as_n, rd_n, wr_n, lo_oe}), 16'h001e);
      rst = 0;
      for (int i = 0; i < 8; i++)
         acc(rows[i]);
      chk("hr_idle", 16'(hr_n), 16'h0001);
      slow = 1;
      acc(rows[1]);
      chk("stretch", 16'(n > 30), 16'h0001);
      slow = 0;
      reset_req = 1;
      @(negedge core_clk);
      reset_req = 0;
      wait_for(1'b0, 4);
      wait_for(1'b1, 2000);
      chk("hr_back", 16'(hr_n), 16'h0001);
      chk("hr_len", 16'(n >= RESET_CYC - 2 && n <= RESET_CYC + 2), 16'h0001);
      card_irq = 1;
      det_a_n = 0;
      repeat (8) @(negedge core_clk);
      chk("irq_on", 16'({irq_p, present}), 16'h0002);
      card_irq = 0;
      det_b_n = 0;
      repeat (8) @(negedge core_clk);
      chk("irq_off", 16'({irq_p, present}), 16'h0001);
      test_done();
   end
endmodule : ata_card_host_port_test

// ===== src/acp_host_port.sv
// acp_host_port: pin-level engine that operates an ata card in register-addressed mode
// assumes user requests on core_clk; card pins pass acp_sync; data pins are split into three signals
// How it works
// - card_task_select_n goes low for task-file accesses and stays high otherwise.
// - card_aux_select_n is a second chip select, low when asserted and high when negated.
// - the three register address outputs carry bits 0 to 2 of the requested card register.
// - register accesses use only data bits 7:0 while bulk transfers use the full 16 bits.
// - a high level on card_irq means a card interrupt is pending.
// - card_io_ready high means ready, and an undriven line reads as ready.
// - both card detect inputs low means a card is present.
// - the card is reset by driving card_hw_reset_n low, which is otherwise held high.
// - card_read_strobe_n goes low for each read cycle and is high between reads.
// - card_write_strobe_n goes low for each write cycle and is high between writes.
// - names ending in _n are asserted low and all other signals are asserted high.
module acp_host_port
   import acp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_aux,
   input wire logic req_bulk,
   input wire logic [2:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic reset_req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic card_irq_pending,
   output logic card_present,
   output logic card_task_select_n,
   output logic card_aux_select_n,
   output logic card_reg_addr_2,
   output logic card_reg_addr_1,
   output logic card_reg_addr_0,
   output logic card_read_strobe_n,
   output logic card_write_strobe_n,
   output logic card_hw_reset_n,
   input wire logic [7:0] card_data_lo_in,
   input wire logic [7:0] card_data_hi_in,
   output logic [7:0] card_data_lo_out,
   output logic [7:0] card_data_hi_out,
   output logic card_data_lo_oe,
   output logic card_data_hi_oe,
   input wire logic card_irq,
   input wire logic card_io_ready,
   input wire logic card_detect_a_n,
   input wire logic card_detect_b_n
);
   import acp_pkg::*;

   acp_pins_if pins ();

   acp_sync u_sync
   (
      .core_clk(core_clk),
      .rst(rst),
      .card_irq(card_irq),
      .card_io_ready(card_io_ready),
      .card_detect_a_n(card_detect_a_n),
      .card_detect_b_n(card_detect_b_n),
      .data_in({card_data_hi_in, card_data_lo_in}),
      .pins(pins.sampler)
   );

   acp_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic write_r;
   logic bulk_r;
   logic cnt_done;
   logic take;

   assign cnt_done = (cnt_r == '0);

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   // the strobe stretches while the card holds io ready low, so slow cards are waited on
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ACP_RESET;
         cnt_r <= CNT_W'(RESET_CYC);
      end
      else
      begin
         case (state_r)
            ACP_IDLE:
            begin
               if (reset_req)
               begin
                  state_r <= ACP_RESET;
                  cnt_r <= CNT_W'(RESET_CYC);
               end
               else if (req_valid)
               begin
                  state_r <= ACP_SETUP;
                  cnt_r <= CNT_W'(SETUP_CYC - 1);
               end
            end
            ACP_SETUP:
            begin
               if (cnt_done)
               begin
                  state_r <= ACP_STROBE;
                  cnt_r <= CNT_W'(STROBE_CYC - 1);
               end
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            ACP_STROBE:
            begin
               if (!cnt_done)
                  cnt_r <= cnt_r - 1'b1;
               else if (pins.ready)
               begin
                  state_r <= ACP_HOLD;
                  cnt_r <= CNT_W'(HOLD_CYC - 1);
               end
            end
            ACP_HOLD:
            begin
               if (cnt_done)
                  state_r <= ACP_IDLE;
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            ACP_RESET:
            begin
               if (cnt_done)
                  state_r <= ACP_IDLE;
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            default:
            begin
               state_r <= ACP_IDLE;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // request capture: address, selects and data held for the whole access
   // ---------------------------------------------------------------
   assign take = (state_r == ACP_IDLE) && req_valid && !reset_req;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         write_r <= 1'b0;
         bulk_r <= 1'b0;
         card_reg_addr_2 <= 1'b0;
         card_reg_addr_1 <= 1'b0;
         card_reg_addr_0 <= 1'b0;
         card_data_lo_out <= 8'h00;
         card_data_hi_out <= BYTE_HI_RST;
      end
      else if (take)
      begin
         write_r <= req_write;
         bulk_r <= req_bulk;
         card_reg_addr_2 <= req_addr[2];
         card_reg_addr_1 <= req_addr[1];
         card_reg_addr_0 <= req_addr[0];
         card_data_lo_out <= req_wdata[7:0];
         card_data_hi_out <= req_bulk ? req_wdata[15:8] : BYTE_HI_RST;
      end
   end

   // selects fall back high in idle so the card never sees a stale select between accesses
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         card_task_select_n <= 1'b1;
         card_aux_select_n <= 1'b1;
      end
      else if (take)
      begin
         card_task_select_n <= req_aux;
         card_aux_select_n <= ~req_aux;
      end
      else if (state_r == ACP_IDLE)
      begin
         card_task_select_n <= 1'b1;
         card_aux_select_n <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // phase decode shared by the strobe and data enable logic
   // ---------------------------------------------------------------
   // a strobe is low from the last setup cycle until the card is ready after the minimum width
   function automatic logic strobe_phase
   (
      input acp_state_t st,
      input logic done,
      input logic ready
   );
      return (st == ACP_SETUP && done) || (st == ACP_STROBE && !(done && ready));
   endfunction : strobe_phase

   // the bus is driven from setup to the last hold cycle so data settles around both strobe edges
   function automatic logic drive_phase
   (
      input acp_state_t st,
      input logic done
   );
      return st == ACP_SETUP || st == ACP_STROBE || (st == ACP_HOLD && !done);
   endfunction : drive_phase

   // ---------------------------------------------------------------
   // read and write strobes
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         card_read_strobe_n <= 1'b1;
         card_write_strobe_n <= 1'b1;
      end
      else
      begin
         card_read_strobe_n <= !(strobe_phase(state_r, cnt_done, pins.ready) && !write_r);
         card_write_strobe_n <= !(strobe_phase(state_r, cnt_done, pins.ready) && write_r);
      end
   end

   // ---------------------------------------------------------------
   // data bus enables
   // ---------------------------------------------------------------
   // a read leaves both byte lanes to the card
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         card_data_lo_oe <= 1'b0;
         card_data_hi_oe <= 1'b0;
      end
      else
      begin
         card_data_lo_oe <= write_r && drive_phase(state_r, cnt_done);
         card_data_hi_oe <= write_r && bulk_r && drive_phase(state_r, cnt_done);
      end
   end

   // ---------------------------------------------------------------
   // card hardware reset
   // ---------------------------------------------------------------
   // the pin falls on the request edge itself, in step with the sequencer entering its reset phase
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         card_hw_reset_n <= 1'b0;
      else
         card_hw_reset_n <= !(state_r == ACP_RESET && !cnt_done) && !(state_r == ACP_IDLE && reset_req);
   end

   // ---------------------------------------------------------------
   // user side handshake
   // ---------------------------------------------------------------
   // req_ready is advisory: it drops as soon as a request or reset is seen, on the same edge that idle is left
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
      end
      else
      begin
         req_ready <= (state_r == ACP_IDLE) && !req_valid && !reset_req;
         rsp_valid <= (state_r == ACP_HOLD) && cnt_done;
      end
   end

   // read data is taken at the end of hold; the two hold cycles are shorter than the four-cycle synchroniser delay, so the level seen is from the strobe
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rsp_rdata <= 16'h0000;
      else if (state_r == ACP_HOLD && cnt_done && !write_r)
         rsp_rdata <= bulk_r ? pins.rd_data : {8'h00, pins.rd_data[7:0]};
   end

   // ---------------------------------------------------------------
   // card status
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         card_irq_pending <= 1'b0;
         card_present <= 1'b0;
      end
      else
      begin
         card_irq_pending <= pins.irq;
         card_present <= pins.present;
      end
   end
endmodule : acp_host_port

// ===== src/acp_pins_if.sv
// acp_pins_if: synchronised card status levels passed from the pin sampler to the core
// assumes both ends run on core_clk
interface acp_pins_if;
   logic irq;
   logic ready;
   logic present;
   logic [15:0] rd_data;

   modport sampler
   (
      output irq,
      output ready,
      output present,
      output rd_data
   );
   modport core
   (
      input irq,
      input ready,
      input present,
      input rd_data
   );
endinterface : acp_pins_if

// ===== src/acp_pkg.sv
// acp_pkg: shared constants and types for the ata card host port
// assumes a single 50 mhz core clock; card pins are sampled through synchronisers
package acp_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned SETUP_NS = 80;
   localparam int unsigned STROBE_NS = 300;
   localparam int unsigned HOLD_NS = 40;
   localparam int unsigned RESET_NS = 25000;
   localparam int unsigned SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 11;

   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 3;
   localparam logic [7:0] BYTE_HI_RST = 8'h00;

   typedef enum logic [4:0]
   {
      ACP_IDLE = 5'b0_0001,
      ACP_SETUP = 5'b0_0010,
      ACP_STROBE = 5'b0_0100,
      ACP_HOLD = 5'b0_1000,
      ACP_RESET = 5'b1_0000
   } acp_state_t;
endpackage : acp_pkg

// ===== src/acp_sync.sv
// acp_sync: three-stage sampling of the card input pins
// assumes pins are asynchronous to core_clk; a level is taken once stages two and three agree
module acp_sync
   import acp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic card_irq,
   input wire logic card_io_ready,
   input wire logic card_detect_a_n,
   input wire logic card_detect_b_n,
   input wire logic [15:0] data_in,
   acp_pins_if.sampler pins
);
   localparam int unsigned N = 20;
   // pin levels with no card: ready and both detects high; every stage starts there so reset shows no false edge
   localparam logic [N-1:0] IDLE_LVL = 20'h7_0000;

   logic [N-1:0] raw;
   logic [N-1:0] s1_r;
   logic [N-1:0] s2_r;
   logic [N-1:0] s3_r;
   logic [N-1:0] lvl_r;

   assign raw = {card_irq, card_io_ready, card_detect_a_n, card_detect_b_n, data_in};

   // ---------------------------------------------------------------
   // synchroniser chain
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= IDLE_LVL;
         s2_r <= IDLE_LVL;
         s3_r <= IDLE_LVL;
      end
      else
      begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a level is taken only once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_lvl
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
               lvl_r[g] <= IDLE_LVL[g];
            else if (s2_r[g] == s3_r[g])
               lvl_r[g] <= s3_r[g];
         end
      end
   endgenerate

   assign pins.irq = lvl_r[19];
   assign pins.ready = lvl_r[18];
   assign pins.present = ~lvl_r[17] & ~lvl_r[16];
   assign pins.rd_data = lvl_r[15:0];
endmodule : acp_sync
